/* File: core/acc_file.v */
// Accumulator file: 32 words of 16 bits, one write port, two registered read ports.
`timescale 1ns/1ps

module acc_file (
   input wire clock_i,
   input wire wr_en_i,
   input wire [4:0] wr_addr_i,
   input wire [15:0] wr_data_i,
   input wire [4:0] rd_a_addr_i,
   input wire [4:0] rd_b_addr_i,
   output reg [15:0] rd_a_data_o,
   output reg [15:0] rd_b_data_o
);

   reg [15:0] mem_r [0:31];

   // Read first, then write: a same-cycle read sees the previous word.
   always @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
      rd_a_data_o <= mem_r[rd_a_addr_i];
      rd_b_data_o <= mem_r[rd_b_addr_i];
   end

endmodule // acc_file

/* File: core/multiply_move_exec.v */
// Decode and execution of the multiply, factor-load, tag-store and subtract-high moves.
`timescale 1ns/1ps
`include "mme_regs.vh"

module multiply_move_exec (
   input wire clock_i,
   input wire arst_n_i,
   input wire instr_valid_i,
   input wire [16:0] instr_i,
   input wire long_addr_i,
   input wire [15:0] ea_i,
   input wire [4:0] run_len_i,
   input wire [1:0] test_flag_i,
   input wire [16:0] dm_rdata_i,
   input wire acc_wr_i,
   input wire [4:0] acc_waddr_i,
   input wire [15:0] acc_wdata_i,
   input wire [4:0] acc_obs_addr_i,
   output reg busy_o,
   output reg done_o,
   output reg illegal_o,
   output reg [1:0] pc_inc_o,
   output reg [15:0] dm_addr_o,
   output reg dm_rd_o,
   output reg dm_tag_wr_o,
   output reg dm_tag_o,
   output reg [15:0] factor_operand_reg_o,
   output reg [15:0] product_high_reg_o,
   output reg [15:0] product_low_reg_o,
   output reg overflow_flag_o,
   output reg sign_flag_o,
   output reg zero_flag_o,
   output reg carry_flag_o,
   output reg tag_flag_o,
   output reg unsigned_factor_flag_o,
   output reg [19:0] acc_pointer_o,
   output wire [15:0] acc_obs_data_o
);

   // -------------------------------------------------------------------------
   // States and operation codes
   // -------------------------------------------------------------------------
   localparam S_IDLE = 4'h1;
   localparam S_READ = 4'h2;
   localparam S_STR = 4'h4;
   localparam S_EXEC = 4'h8;

   localparam OP_NONE = 4'h0;
   localparam OP_SUBH = 4'h1;
   localparam OP_TAGST = 4'h2;
   localparam OP_UFL_ACC = 4'h3;
   localparam OP_UFL_MEM = 4'h4;
   localparam OP_MUL_ACC = 4'h5;
   localparam OP_MUL_MEM = 4'h6;
   localparam OP_ROUNDED_PRODUCT_MEM_OP = 4'h7;
   localparam OP_STRMUL = 4'h8;
   localparam OP_MAC_MEM = 4'h9;
   localparam OP_MAC_ACC = 4'ha;

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   // Signed 17 x 17 product; callers choose signedness by the extension bit.
   function [33:0] mul17;
      input [16:0] a;
      input [16:0] b;
      begin
         mul17 = $signed(a) * $signed(b);
      end
   endfunction

   // Accumulator word address: pointer, optional partner half, word offset.
   function [4:0] acc_addr;
      input [4:0] ptr;
      input partner;
      input [4:0] ofs;
      begin
         acc_addr = ptr + (partner ? `PARTNER_OFS : 5'h00) + ofs;
      end
   endfunction

   // Pointer of one accumulator out of the packed pointer bank.
   function [4:0] get_ap;
      input [19:0] ap;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: get_ap = ap[4:0];
            2'h1: get_ap = ap[9:5];
            2'h2: get_ap = ap[14:10];
            default: get_ap = ap[19:15];
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [3:0] state_r;
   reg [3:0] op_r;
   reg [1:0] sel_r;
   reg src_part_r;
   reg dst_part_r;
   reg mem_src_r;
   reg [4:0] len_m1_r;
   reg [4:0] k_r;
   reg [17:0] carry_r;

   // -------------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------------
   reg [3:0] dec_op;
   reg dec_mem;
   wire [5:0] sub_code = instr_i[7:2];

   // The string multiply shares the group prefix with premodify code 3, so it
   // is tested first and code 3 is refused for the premodifying forms.
   always @* begin
      dec_op = OP_NONE;
      if (instr_i[16:10] == `OPC_STRMUL && sub_code == `SUB_MUL && !instr_i[0]) begin
         dec_op = OP_STRMUL;
      end else if (instr_i[16:12] == `OPC_ACCGRP && instr_i[11:10] != `PREM_RSVD) begin
         if (sub_code == `SUB_UFL && !instr_i[0]) begin
            dec_op = OP_UFL_ACC;
         end else if (sub_code == `SUB_MUL && !instr_i[0]) begin
            dec_op = OP_MUL_ACC;
         end else if (sub_code == `SUB_MAC && instr_i[0] != instr_i[1]) begin
            dec_op = OP_MAC_ACC;
         end
      end else if (instr_i[16:10] == `OPC_SUBH) begin
         dec_op = OP_SUBH;
      end else if (instr_i[16:10] == `OPC_MAC_MEM) begin
         dec_op = OP_MAC_MEM;
      end else if (instr_i[16:9] == `OPC_TAGST) begin
         dec_op = OP_TAGST;
      end else if (instr_i[16:8] == `OPC_UFL_MEM) begin
         dec_op = OP_UFL_MEM;
      end else if (instr_i[16:8] == `OPC_MUL_MEM) begin
         dec_op = OP_MUL_MEM;
      end else if (instr_i[16:8] == `OPC_ROUNDED_PRODUCT_MEM_OP) begin
         dec_op = OP_ROUNDED_PRODUCT_MEM_OP;
      end
      dec_mem = (dec_op == OP_SUBH) || (dec_op == OP_TAGST) || (dec_op == OP_UFL_MEM) ||
                (dec_op == OP_MUL_MEM) || (dec_op == OP_ROUNDED_PRODUCT_MEM_OP) || (dec_op == OP_MAC_MEM);
   end

   // -------------------------------------------------------------------------
   // Pointer premodify at acceptance, so the read that follows uses it
   // -------------------------------------------------------------------------
   wire [4:0] new_ap_old = get_ap(acc_pointer_o, instr_i[9:8]);
   reg [4:0] new_ap;
   reg [19:0] ap_nxt;

   always @* begin
      case (instr_i[11:10])
         `PREM_INC: new_ap = new_ap_old + 5'h01;
         `PREM_DEC: new_ap = new_ap_old - 5'h01;
         default: new_ap = new_ap_old;
      endcase
      ap_nxt = acc_pointer_o;
      case (instr_i[9:8])
         2'h0: ap_nxt[4:0] = new_ap;
         2'h1: ap_nxt[9:5] = new_ap;
         2'h2: ap_nxt[14:10] = new_ap;
         default: ap_nxt[19:15] = new_ap;
      endcase
   end

   wire accept = (state_r == S_IDLE) && instr_valid_i && (dec_op != OP_NONE);
   wire premod_op = (dec_op == OP_UFL_ACC) || (dec_op == OP_MUL_ACC) || (dec_op == OP_MAC_ACC);

   // -------------------------------------------------------------------------
   // Accumulator file addressing
   // -------------------------------------------------------------------------
   wire [4:0] cur_ap = get_ap(acc_pointer_o, sel_r);
   wire [4:0] k_inc = k_r + 5'h01;
   reg [4:0] rd_a_ofs;
   reg [4:0] rd_a_addr;
   reg [4:0] rd_b_addr;
   wire [15:0] rd_a;
   wire [15:0] rd_b;

   // Port B serves the destination while busy and the observation port otherwise.
   always @* begin
      if (op_r == OP_SUBH) begin
         rd_a_ofs = `SECOND_WORD_OFS;
      end else if (state_r == S_STR) begin
         rd_a_ofs = k_inc;
      end else begin
         rd_a_ofs = 5'h00;
      end
      rd_a_addr = acc_addr(cur_ap, src_part_r, rd_a_ofs);
      rd_b_addr = busy_o ? acc_addr(cur_ap, dst_part_r, 5'h00) : acc_obs_addr_i;
   end

   // -------------------------------------------------------------------------
   // Arithmetic
   // -------------------------------------------------------------------------
   wire [15:0] src_w = mem_src_r ? dm_rdata_i[15:0] : rd_a;
   wire fac_ext = !unsigned_factor_flag_o && factor_operand_reg_o[15];
   wire [33:0] prod_full = mul17({fac_ext, factor_operand_reg_o}, {src_w[15], src_w});
   wire [31:0] prod = prod_full[31:0];
   wire [32:0] rnd = {1'b0, prod} + {1'b0, `ROUND_CONST};
   wire [16:0] diff = {1'b0, rd_a} - {1'b0, product_high_reg_o};
   wire [16:0] sum = {1'b0, rd_b} + {1'b0, prod[15:0]};
   wire sub_ovf = (rd_a[15] != product_high_reg_o[15]) && (diff[15] != rd_a[15]);
   wire add_ovf = (rd_b[15] == prod[15]) && (sum[15] != rd_b[15]);
   wire rnd_ovf = !prod[31] && rnd[31];

   // String step: lower words are unsigned, the top word carries the sign, and
   // the rounding half-LSB is folded into the final step only.
   wire is_last = (k_r == len_m1_r);
   wire [33:0] str_prod = mul17({fac_ext, factor_operand_reg_o}, {is_last & rd_a[15], rd_a});
   wire [33:0] str_t = str_prod + {{16{carry_r[17]}}, carry_r} +
                       (is_last ? {2'h0, `ROUND_CONST} : 34'h0_0000_0000);

   // -------------------------------------------------------------------------
   // Accumulator write port
   // -------------------------------------------------------------------------
   reg wr_en;
   reg [4:0] wr_addr;
   reg [15:0] wr_data;

   // External loads are taken only while idle; execution owns the port otherwise.
   always @* begin
      wr_en = acc_wr_i && !busy_o;
      wr_addr = acc_waddr_i;
      wr_data = acc_wdata_i;
      if (state_r == S_EXEC && op_r == OP_SUBH) begin
         wr_en = 1'b1;
         wr_addr = acc_addr(cur_ap, 1'b0, `SECOND_WORD_OFS);
         wr_data = diff[15:0];
      end else if (state_r == S_EXEC && (op_r == OP_MAC_MEM || op_r == OP_MAC_ACC)) begin
         wr_en = 1'b1;
         wr_addr = acc_addr(cur_ap, dst_part_r, 5'h00);
         wr_data = sum[15:0];
      end
   end

   acc_file u_acc_file (
      .clock_i(clock_i),
      .wr_en_i(wr_en),
      .wr_addr_i(wr_addr),
      .wr_data_i(wr_data),
      .rd_a_addr_i(rd_a_addr),
      .rd_b_addr_i(rd_b_addr),
      .rd_a_data_o(rd_a),
      .rd_b_data_o(rd_b)
   );

   assign acc_obs_data_o = rd_b;

   // -------------------------------------------------------------------------
   // Sequencer and architectural registers
   // -------------------------------------------------------------------------
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= S_IDLE;
         op_r <= OP_NONE;
         sel_r <= 2'h0;
         src_part_r <= 1'b0;
         dst_part_r <= 1'b0;
         mem_src_r <= 1'b0;
         len_m1_r <= 5'h00;
         k_r <= 5'h00;
         carry_r <= 18'h0_0000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         illegal_o <= 1'b0;
         pc_inc_o <= 2'h1;
         dm_addr_o <= `WORD_RST;
         dm_rd_o <= 1'b0;
         dm_tag_wr_o <= 1'b0;
         dm_tag_o <= 1'b0;
         factor_operand_reg_o <= `WORD_RST;
         product_high_reg_o <= `WORD_RST;
         product_low_reg_o <= `WORD_RST;
         overflow_flag_o <= `FLAG_RST;
         sign_flag_o <= `FLAG_RST;
         zero_flag_o <= `FLAG_RST;
         carry_flag_o <= `FLAG_RST;
         tag_flag_o <= `FLAG_RST;
         unsigned_factor_flag_o <= `FLAG_RST;
         acc_pointer_o <= `AP_RST;
      end else begin
         done_o <= 1'b0;
         illegal_o <= 1'b0;
         dm_rd_o <= 1'b0;
         dm_tag_wr_o <= 1'b0;
         case (state_r)
            S_IDLE: begin
               illegal_o <= instr_valid_i && (dec_op == OP_NONE);
               if (accept) begin
                  state_r <= S_READ;
                  busy_o <= 1'b1;
                  op_r <= dec_op;
                  sel_r <= instr_i[9:8];
                  src_part_r <= (dec_op == OP_SUBH || dec_op == OP_STRMUL) ? 1'b0 : instr_i[1];
                  // Memory forms carry address bits in bit 0, so they never pick the partner.
                  dst_part_r <= dec_mem ? 1'b0 : instr_i[0];
                  mem_src_r <= dec_mem;
                  len_m1_r <= run_len_i + `STR_LAST_OFS;
                  k_r <= 5'h00;
                  carry_r <= 18'h0_0000;
                  pc_inc_o <= (dec_mem && long_addr_i) ? 2'h2 : 2'h1;
                  dm_addr_o <= ea_i;
                  dm_rd_o <= dec_mem && (dec_op != OP_TAGST);
                  dm_tag_wr_o <= (dec_op == OP_TAGST);
                  dm_tag_o <= instr_i[8] ? test_flag_i[1] : test_flag_i[0];
                  if (premod_op) begin
                     acc_pointer_o <= ap_nxt;
                  end
               end
            end
            S_READ: begin
               state_r <= (op_r == OP_STRMUL) ? S_STR : S_EXEC;
            end
            S_STR: begin
               // One word per cycle; the operand register sits a cycle behind its address.
               k_r <= k_inc;
               carry_r <= str_t[33:16];
               if (is_last) begin
                  product_high_reg_o <= str_t[31:16];
                  state_r <= S_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
            S_EXEC: begin
               state_r <= S_IDLE;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               if (mem_src_r && op_r != OP_TAGST) begin
                  tag_flag_o <= dm_rdata_i[16];
               end
               case (op_r)
                  OP_SUBH: begin
                     factor_operand_reg_o <= dm_rdata_i[15:0];
                     overflow_flag_o <= sub_ovf;
                     sign_flag_o <= diff[15];
                     zero_flag_o <= (diff[15:0] == 16'h0000);
                     carry_flag_o <= !diff[16];
                  end
                  OP_UFL_ACC: begin
                     factor_operand_reg_o <= rd_a;
                     unsigned_factor_flag_o <= 1'b1;
                  end
                  OP_UFL_MEM: begin
                     factor_operand_reg_o <= dm_rdata_i[15:0];
                     unsigned_factor_flag_o <= 1'b1;
                  end
                  OP_MUL_ACC: begin
                     product_high_reg_o <= rnd[31:16];
                     product_low_reg_o <= rnd[15:0];
                     overflow_flag_o <= rnd_ovf;
                     sign_flag_o <= rnd[31];
                     zero_flag_o <= (rnd[31:0] == 32'h0000_0000);
                     carry_flag_o <= rnd[32];
                  end
                  OP_MUL_MEM: begin
                     product_high_reg_o <= prod[31:16];
                     product_low_reg_o <= prod[15:0];
                  end
                  OP_ROUNDED_PRODUCT_MEM_OP: begin
                     product_high_reg_o <= rnd[31:16];
                     product_low_reg_o <= rnd[15:0];
                  end
                  OP_MAC_MEM, OP_MAC_ACC: begin
                     product_high_reg_o <= prod[31:16];
                     product_low_reg_o <= prod[15:0];
                     overflow_flag_o <= add_ovf;
                     sign_flag_o <= sum[15];
                     zero_flag_o <= (sum[15:0] == 16'h0000);
                     carry_flag_o <= sum[16];
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               state_r <= S_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // multiply_move_exec

/* File: dv/dm_model.sv */
// Data memory model with a tag bit per word, answering the block's strobes.
`timescale 1ns/1ps

module dm_model (
   input wire logic clock_i,
   input wire logic dm_rd_i,
   input wire logic [15:0] dm_addr_i,
   input wire logic dm_tag_wr_i,
   input wire logic dm_tag_i,
   output logic [16:0] dm_rdata_o
);
   logic [16:0] mem_r [0:255];

   initial dm_rdata_o = 17'h05a5a;

   // Preload hook used by the bench before any traffic.
   task automatic load(input logic [7:0] a, input logic [16:0] v);
      mem_r[a] = v;
   endtask

   // The word is shown for one cycle only; otherwise the bus toggles so stale data never matches.
   always @(posedge clock_i) begin
      if (dm_rd_i) begin
         dm_rdata_o <= mem_r[dm_addr_i[7:0]];
      end else begin
         dm_rdata_o <= ~dm_rdata_o;
      end
      if (dm_tag_wr_i) begin
         mem_r[dm_addr_i[7:0]][16] <= dm_tag_i;
      end
   end
endmodule // dm_model

/* File: dv/mme_checker_props.sv */
// Port-level assertions for the multiply and move block.
`timescale 1ns/1ps

module mme_checker (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic instr_valid_i,
   input wire logic [16:0] instr_i,
   input wire logic long_addr_i,
   input wire logic [15:0] ea_i,
   input wire logic [1:0] test_flag_i,
   input wire logic [16:0] dm_rdata_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic illegal_o,
   input wire logic [1:0] pc_inc_o,
   input wire logic [15:0] dm_addr_o,
   input wire logic dm_rd_o,
   input wire logic dm_tag_wr_o,
   input wire logic dm_tag_o,
   input wire logic [15:0] factor_operand_reg_o,
   input wire logic overflow_flag_o,
   input wire logic sign_flag_o,
   input wire logic zero_flag_o,
   input wire logic carry_flag_o,
   input wire logic tag_flag_o,
   input wire logic unsigned_factor_flag_o
);
   // ------------------------------------------------------------
   // Helper nets, so that the sampled functions see plain signals.
   // ------------------------------------------------------------
   wire [3:0] arith_w = {overflow_flag_o, sign_flag_o, zero_flag_o, carry_flag_o};
   wire [4:0] flags_w = {arith_w, tag_flag_o};
   wire [8:0] op9_w = instr_i[16:8];
   wire [6:0] op7_w = instr_i[16:10];
   wire sel_flag_w = instr_i[8] ? test_flag_i[1] : test_flag_i[0];
   wire [15:0] word_w = dm_rdata_i[15:0];
   wire word_tag_w = dm_rdata_i[16];

   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   sequence accept_seq;
      $rose(busy_o);
   endsequence
   sequence ufl_mem_seq;
      accept_seq and ($past(op9_w) == 9'h1b9);
   endsequence
   sequence rounded_product_mem_op_seq;
      accept_seq and ($past(op9_w) == 9'h1ba);
   endsequence

   done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
   done_idle_a: assert property (done_o |-> !busy_o && $past(busy_o)) else $error("done not at end");
   busy_bound_a: assert property (accept_seq |-> ##[2:40] done_o) else $error("no completion");
   illegal_idle_a: assert property (illegal_o |-> !busy_o && $past(instr_valid_i))
      else $error("refusal without request");
   read_strobe_a: assert property (dm_rd_o |-> accept_seq ##1 !dm_rd_o) else $error("bad read strobe");
   addr_latch_a: assert property (accept_seq |-> dm_addr_o == $past(ea_i)) else $error("bad address");
   tag_value_a: assert property (dm_tag_wr_o |-> dm_tag_o == $past(sel_flag_w))
      else $error("wrong tag bit");
   tag_keep_a: assert property (dm_tag_wr_o |-> ##2 flags_w == $past(flags_w, 2))
      else $error("tag store changed flags");
   second_word_a: assert property (accept_seq and $past(long_addr_i) && $past(op7_w) == 7'h33
      |-> pc_inc_o == 2'h2) else $error("second word not counted");
   ufl_mem_a: assert property (ufl_mem_seq |-> ##2 unsigned_factor_flag_o
      && factor_operand_reg_o == $past(word_w) && tag_flag_o == $past(word_tag_w))
      else $error("memory factor load wrong");
   rounded_product_mem_op_keep_a: assert property (rounded_product_mem_op_seq |-> ##2 arith_w == $past(arith_w, 2))
      else $error("rounded multiply changed flags");
endmodule // mme_checker

bind multiply_move_exec mme_checker u_mme_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i), .long_addr_i(long_addr_i), .ea_i(ea_i),
   .test_flag_i(test_flag_i), .dm_rdata_i(dm_rdata_i), .busy_o(busy_o), .done_o(done_o),
   .illegal_o(illegal_o), .pc_inc_o(pc_inc_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o),
   .dm_tag_wr_o(dm_tag_wr_o), .dm_tag_o(dm_tag_o), .factor_operand_reg_o(factor_operand_reg_o),
   .overflow_flag_o(overflow_flag_o), .sign_flag_o(sign_flag_o), .zero_flag_o(zero_flag_o),
   .carry_flag_o(carry_flag_o), .tag_flag_o(tag_flag_o),
   .unsigned_factor_flag_o(unsigned_factor_flag_o));

/* File: dv/multiply_move_exec_bench.sv */
// Self-checking bench for the multiply and move block.
`timescale 1ns/1ps

module multiply_move_exec_bench;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [16:0] instr_i = 17'h00000;
   logic long_addr_i = 1'b0;
   logic [15:0] ea_i = 16'h0000;
   logic [4:0] run_len_i = 5'h00;
   logic [1:0] test_flag_i = 2'h2;
   logic acc_wr_i = 1'b0;
   logic [4:0] acc_waddr_i = 5'h00;
   logic [15:0] acc_wdata_i = 16'h0000;
   logic [4:0] acc_obs_addr_i = 5'h00;
   wire [16:0] dm_rdata_i;
   wire busy_o, done_o, illegal_o, dm_rd_o, dm_tag_wr_o, dm_tag_o;
   wire of_w, sf_w, zf_w, cf_w, tf_w, uf_w;
   wire [1:0] pc_inc_o;
   wire [15:0] dm_addr_o, fac_w, ph_w, pl_w, acc_obs_data_o;
   wire [19:0] acc_pointer_o;
   int n_mismatch = 0;
   int check_count = 0;
   logic c1_busy, c1_ill, c1_twr, c1_tag;
   logic [19:0] n_cyc;
   logic [15:0] rd_v;

   always #2.5 clock_i = ~clock_i;

   multiply_move_exec dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .long_addr_i(long_addr_i), .ea_i(ea_i),
      .run_len_i(run_len_i), .test_flag_i(test_flag_i), .dm_rdata_i(dm_rdata_i),
      .acc_wr_i(acc_wr_i), .acc_waddr_i(acc_waddr_i), .acc_wdata_i(acc_wdata_i),
      .acc_obs_addr_i(acc_obs_addr_i), .busy_o(busy_o), .done_o(done_o),
      .illegal_o(illegal_o), .pc_inc_o(pc_inc_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o),
      .dm_tag_wr_o(dm_tag_wr_o), .dm_tag_o(dm_tag_o), .factor_operand_reg_o(fac_w),
      .product_high_reg_o(ph_w), .product_low_reg_o(pl_w), .overflow_flag_o(of_w),
      .sign_flag_o(sf_w), .zero_flag_o(zf_w), .carry_flag_o(cf_w), .tag_flag_o(tf_w),
      .unsigned_factor_flag_o(uf_w), .acc_pointer_o(acc_pointer_o),
      .acc_obs_data_o(acc_obs_data_o));

   dm_model u_mem (.clock_i(clock_i), .dm_rd_i(dm_rd_o), .dm_addr_i(dm_addr_o),
      .dm_tag_wr_i(dm_tag_wr_o), .dm_tag_i(dm_tag_o), .dm_rdata_o(dm_rdata_i));

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Issues one instruction and waits for completion; cycle-1 strobes are captured on the way.
   task automatic exec(input logic [16:0] ins, input logic lng, input logic [15:0] ea);
      instr_i = ins;
      long_addr_i = lng;
      ea_i = ea;
      instr_valid_i = 1'b1;
      @(posedge clock_i);
      #1;
      instr_valid_i = 1'b0;
      c1_busy = busy_o;
      c1_ill = illegal_o;
      c1_twr = dm_tag_wr_o;
      c1_tag = dm_tag_o;
      n_cyc = 20'h1;
      while (c1_busy === 1'b1 && done_o !== 1'b1 && n_cyc < 20'h3c) begin
         @(posedge clock_i);
         #1;
         n_cyc = n_cyc + 20'h1;
      end
      if (c1_busy !== 1'b1) begin
         @(posedge clock_i);
         #1;
      end
   endtask

   task automatic wr_acc(input logic [4:0] a, input logic [15:0] d);
      acc_waddr_i = a;
      acc_wdata_i = d;
      acc_wr_i = 1'b1;
      @(posedge clock_i);
      #1;
      acc_wr_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask

   task automatic rd_acc(input logic [4:0] a);
      acc_obs_addr_i = a;
      @(posedge clock_i);
      @(posedge clock_i);
      #1;
      rd_v = acc_obs_data_o;
   endtask

   task automatic fin(input string nm);
      $display("test %s finished, mismatches %0d", nm, n_mismatch);
   endtask

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      #20000;
      n_mismatch++;
      $display("watchdog expired");
      complete_run();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      u_mem.load(8'h20, 17'h11234);
      u_mem.load(8'h21, 17'h00009);
      u_mem.load(8'h22, 17'h01235);
      repeat (10) @(posedge clock_i);
      #1;
      arst_n_i = 1'b1;
      chk({busy_o, pc_inc_o, fac_w, uf_w}, 32'h00020000);
      wr_acc(5'h00, 16'h0100);
      wr_acc(5'h01, 16'h0005);
      rd_acc(5'h01);
      chk(rd_v, 16'h0005);
      fin("reset and accumulators");
      exec({9'h1b9, 8'h20}, 1'b1, 16'h0020);
      chk({pc_inc_o, fac_w, uf_w, tf_w}, {2'h2, 16'h1234, 2'h3});
      chk(n_cyc, 20'h3);
      exec({9'h1bb, 8'h21}, 1'b0, 16'h0021);
      chk({ph_w, pl_w}, 32'h0000a3d4);
      chk({of_w, sf_w, zf_w, cf_w, tf_w, pc_inc_o}, 7'h01);
      exec({9'h1ba, 8'h21}, 1'b0, 16'h0021);
      chk({ph_w, pl_w}, 32'h000123d4);
      rd_acc(5'h00);
      chk(rd_v, 16'h0100);
      fin("memory multiplies");
      exec({7'h33, 2'h0, 8'h22}, 1'b1, 16'h0022);
      chk({pc_inc_o, fac_w}, {2'h2, 16'h1235});
      chk({of_w, sf_w, zf_w, cf_w, tf_w}, 5'h02);
      rd_acc(5'h01);
      chk(rd_v, 16'h0004);
      exec({7'h36, 2'h0, 8'h21}, 1'b0, 16'h0021);
      chk({ph_w, pl_w}, 32'h0000a3dd);
      chk({of_w, sf_w, zf_w, cf_w, tf_w}, 5'h08);
      rd_acc(5'h00);
      chk(rd_v, 16'ha4dd);
      fin("subtract and accumulate");
      for (int b = 0; b < 2; b++) begin
         exec({8'hd7, b[0], 8'h30}, b[0], 16'h0030);
         chk({c1_twr, c1_tag, pc_inc_o}, {1'b1, b[0], b[0], ~b[0]});
         chk(u_mem.mem_r[8'h30][16], b[0]);
      end
      chk({of_w, sf_w, zf_w, cf_w, tf_w}, 5'h08);
      fin("tag store");
      exec({5'h1c, 2'h3, 2'h0, 6'h2e, 2'h0}, 1'b0, 16'h0000);
      chk({c1_busy, c1_ill, acc_pointer_o}, 22'h100000);
      exec({5'h1c, 2'h1, 2'h0, 6'h2e, 2'h0}, 1'b0, 16'h0000);
      chk({acc_pointer_o, fac_w, uf_w}, {20'h00001, 16'h0004, 1'b1});
      exec({5'h1c, 2'h2, 2'h0, 6'h3c, 2'h0}, 1'b0, 16'h0000);
      chk(acc_pointer_o, 20'h00000);
      chk({ph_w, pl_w}, 32'hffff1374);
      chk({of_w, sf_w, zf_w, cf_w}, 4'h4);
      fin("accumulator forms");
      exec({7'h73, 2'h0, 6'h3c, 2'h0}, 1'b0, 16'h0000);
      chk(n_cyc, 20'h4);
      chk({ph_w, pl_w}, 32'h00001374);
      chk({of_w, sf_w, zf_w, cf_w, tf_w}, 5'h08);
      fin("string multiply");
      complete_run();
   end
endmodule // multiply_move_exec_bench

/* File: include/mme_regs.vh */
// Opcode patterns, premodify codes, reset values and constants of the multiply/move block.
`ifndef MME_REGS_VH
`define MME_REGS_VH

// ----------------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------------
`define OPC_SUBH 7'h33
`define OPC_TAGST 8'hd7
`define OPC_ACCGRP 5'h1c
`define OPC_STRMUL 7'h73
`define OPC_UFL_MEM 9'h1b9
`define OPC_MUL_MEM 9'h1bb
`define OPC_ROUNDED_PRODUCT_MEM_OP 9'h1ba
`define OPC_MAC_MEM 7'h36
`define SUB_UFL 6'h2e
`define SUB_MUL 6'h3c
`define SUB_MAC 6'h32

// ----------------------------------------------------------------------------
// Pointer premodify codes
// ----------------------------------------------------------------------------
`define PREM_NONE 2'h0
`define PREM_INC 2'h1
`define PREM_DEC 2'h2
`define PREM_RSVD 2'h3

// ----------------------------------------------------------------------------
// Arithmetic and layout constants
// ----------------------------------------------------------------------------
`define ROUND_CONST 32'h0000_8000
`define STR_LAST_OFS 5'h01
`define PARTNER_OFS 5'h10
`define SECOND_WORD_OFS 5'h01
`define FLAG_RST 1'b0
`define WORD_RST 16'h0000
`define AP_RST 20'h00000

`endif
